//--- lpb_timing.sv
// LCD timing top: control word, pixel clock prescaler, line clock, AC bias, gray depth.
// Assumes the 40 MHz clock stands in for the fixed pixel source; registers on a plain port.
//
// Behaviour
// - pixel clock = source divided by prescale+1
// - prescale zero gives no pixel clock
// - bias toggles after n+1 line clock pulses
// - low depth bit selects 1 or 2/4 bpp
// - high depth bit selects 4 versus 2 bpp
// - pixels always pass through the palette
// - low time doubled after each line pulse
// - line length field gives pixels/16 minus one
`timescale 1ns/100ps
`default_nettype none
module lpb_timing
  import lpb_pkg::*;
#(
  parameter int LINES = LPB_LINES_DFLT
)
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic [3:0]  pixel_data_i,
  output logic             pixel_req_o,
  output logic             pixel_shift_clock_o,
  output logic             line_clock_pulse_o,
  output logic             frame_start_o,
  output logic             ac_bias_o,
  output logic      [3:0]  gray_level_o,
  output logic      [1:0]  bits_per_pixel_o
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic [6:0]  div_cnt;
    logic        pclk;
    logic        stretch;
    logic        stretched;
    logic [9:0]  pix_cnt;
    logic [9:0]  line_cnt;
    logic        lclk;
    logic        fstart;
    logic [4:0]  ac_cnt;
    logic        bias;
    logic [3:0]  pix_word;
  } lpb_state_t;

  lpb_state_t s_r;
  lpb_state_t s_nxt;
  logic       rst_n;
  logic       rst_sync1_r;
  logic       rst_sync2_r;
  logic [63:0] pal_table;
  logic [3:0]  pal_level;
  logic [3:0]  pal_index;
  lpb_depth_t  depth;

  // Release of the asynchronous reset through two flops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end
  assign rst_n = rst_sync2_r;

  function automatic lpb_depth_t decode_depth(input logic [31:0] c);
    if (!c[LPB_GLOW_BIT]) begin
      decode_depth = LPB_BPP1;
    end else if (c[LPB_GHIGH_BIT]) begin
      decode_depth = LPB_BPP4;
    end else begin
      decode_depth = LPB_BPP2;
    end
  endfunction

  function automatic logic [1:0] depth_code(input lpb_depth_t d);
    case (d)
      LPB_BPP1: depth_code = 2'h0;
      LPB_BPP2: depth_code = 2'h1;
      LPB_BPP4: depth_code = 2'h3;
      default:  depth_code = 2'h0;
    endcase
  endfunction

  logic [5:0] pre;
  logic [5:0] llen;
  logic [4:0] acpre;
  logic [9:0] pix_last;
  assign pre      = s_r.ctrl[LPB_PPRE_LSB +: 6];
  assign llen     = s_r.ctrl[LPB_LLEN_LSB +: 6];
  assign acpre    = s_r.ctrl[LPB_ACPRE_LSB +: 5];
  assign pix_last = {llen, 4'hF};
  assign depth    = decode_depth(s_r.ctrl);

  // Every pixel index goes through the palette; no bypass exists
  always_comb begin
    case (depth)
      LPB_BPP1: pal_index = {3'h0, pixel_data_i[0]};
      LPB_BPP2: pal_index = {2'h0, pixel_data_i[1:0]};
      default:  pal_index = pixel_data_i;
    endcase
  end

  lpb_palette u_pal (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .wr_lo_i (wr_i && addr_i == LPB_ADDR_PAL_LO),
    .wr_hi_i (wr_i && addr_i == LPB_ADDR_PAL_HI),
    .wdata_i (wdata_i),
    .index_i (pal_index),
    .table_o (pal_table),
    .level_o (pal_level)
  );

  logic pclk_fall;
  logic [6:0] half_lim;
  logic [6:0] hi_len;

  always_comb begin
    s_nxt = s_r;
    s_nxt.lclk = 1'b0;
    s_nxt.fstart = 1'b0;
    pclk_fall = 1'b0;
    if (wr_i && addr_i == LPB_ADDR_CTRL) begin
      s_nxt.ctrl = wdata_i;
    end
    case (addr_i)
      LPB_ADDR_CTRL:   s_nxt.rdata = s_r.ctrl;
      LPB_ADDR_PAL_LO: s_nxt.rdata = pal_table[31:0];
      LPB_ADDR_PAL_HI: s_nxt.rdata = pal_table[63:32];
      LPB_ADDR_STATUS: s_nxt.rdata = {12'h000, s_r.line_cnt, s_r.pix_cnt};
      default:         s_nxt.rdata = 32'h0000_0000;
    endcase
    if (!rd_i) begin
      s_nxt.rdata = 32'h0000_0000;
    end
    // Whole period is pre+1 source cycles; odd counts give the low half the spare cycle
    hi_len   = ({1'b0, pre} + 7'h01) >> 1;
    half_lim = s_r.pclk ? hi_len - 7'h01 : {1'b0, pre} - hi_len;
    if (pre == 6'h00) begin
      s_nxt.div_cnt = 7'h00;
      s_nxt.pclk = 1'b0;
    end else if (s_r.div_cnt >= half_lim) begin
      s_nxt.div_cnt = 7'h00;
      if (s_r.pclk) begin
        s_nxt.pclk = 1'b0;
        pclk_fall = 1'b1;
      end else if (s_r.stretch && !s_r.stretched) begin
        s_nxt.stretched = 1'b1;
      end else begin
        s_nxt.pclk = 1'b1;
        s_nxt.stretch = 1'b0;
        s_nxt.stretched = 1'b0;
      end
    end else begin
      s_nxt.div_cnt = s_r.div_cnt + 7'h01;
    end
    if (pclk_fall) begin
      s_nxt.pix_word = pal_level;
      if (s_r.pix_cnt == pix_last) begin
        s_nxt.pix_cnt = 10'h000;
        s_nxt.lclk = 1'b1;
        s_nxt.stretch = 1'b1;
        if (s_r.ac_cnt >= acpre) begin
          s_nxt.ac_cnt = 5'h00;
          s_nxt.bias = !s_r.bias;
        end else begin
          s_nxt.ac_cnt = s_r.ac_cnt + 5'h01;
        end
        // Line count is a parameter; the AC prescale choice is software's
        if (s_r.line_cnt == 10'(LINES - 1)) begin
          s_nxt.line_cnt = 10'h000;
          s_nxt.fstart = 1'b1;
        end else begin
          s_nxt.line_cnt = s_r.line_cnt + 10'h001;
        end
      end else begin
        s_nxt.pix_cnt = s_r.pix_cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_r.ctrl      <= LPB_CTRL_RESET;
      s_r.rdata     <= 32'h0000_0000;
      s_r.div_cnt   <= 7'h00;
      s_r.pclk      <= 1'b0;
      s_r.stretch   <= 1'b0;
      s_r.stretched <= 1'b0;
      s_r.pix_cnt   <= 10'h000;
      s_r.line_cnt  <= 10'h000;
      s_r.lclk      <= 1'b0;
      s_r.fstart    <= 1'b0;
      s_r.ac_cnt    <= 5'h00;
      s_r.bias      <= 1'b0;
      s_r.pix_word  <= 4'h0;
    end else if (ce_i) begin
      s_r.ctrl      <= s_nxt.ctrl;
      s_r.rdata     <= s_nxt.rdata;
      s_r.div_cnt   <= s_nxt.div_cnt;
      s_r.pclk      <= s_nxt.pclk;
      s_r.stretch   <= s_nxt.stretch;
      s_r.stretched <= s_nxt.stretched;
      s_r.pix_cnt   <= s_nxt.pix_cnt;
      s_r.line_cnt  <= s_nxt.line_cnt;
      s_r.lclk      <= s_nxt.lclk;
      s_r.fstart    <= s_nxt.fstart;
      s_r.ac_cnt    <= s_nxt.ac_cnt;
      s_r.bias      <= s_nxt.bias;
      s_r.pix_word  <= s_nxt.pix_word;
    end
  end

  assign rdata_o             = s_r.rdata;
  // Gated so a frozen block never shows a standing request
  assign pixel_req_o         = pclk_fall && ce_i;
  assign pixel_shift_clock_o = s_r.pclk;
  assign line_clock_pulse_o  = s_r.lclk;
  assign frame_start_o       = s_r.fstart;
  assign ac_bias_o           = s_r.bias;
  assign gray_level_o        = s_r.pix_word;
  assign bits_per_pixel_o    = depth_code(depth);
endmodule
`default_nettype wire

//--- lpb_pkg.sv
// Package for the LCD pixel clock, AC bias and grayscale timing block.
// Assumes a 40 MHz system clock and a plain register port.
package lpb_pkg;
  localparam logic [3:0]  LPB_ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  LPB_ADDR_PAL_LO  = 4'h1;
  localparam logic [3:0]  LPB_ADDR_PAL_HI  = 4'h2;
  localparam logic [3:0]  LPB_ADDR_STATUS  = 4'h3;
  localparam int          LPB_VBUF_LSB     = 0;
  localparam int          LPB_LLEN_LSB     = 13;
  localparam int          LPB_PPRE_LSB     = 19;
  localparam int          LPB_ACPRE_LSB    = 25;
  localparam int          LPB_GLOW_BIT     = 30;
  localparam int          LPB_GHIGH_BIT    = 31;
  localparam logic [31:0] LPB_CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] LPB_PAL_RESET    = 32'h0000_0000;
  localparam int          LPB_PIX_PER_UNIT = 16;
  localparam int          LPB_LINES_DFLT   = 240;
  typedef enum logic [1:0] {LPB_BPP1, LPB_BPP2, LPB_BPP4} lpb_depth_t;
endpackage

//--- lpb_palette.sv
// Palette store: sixteen 4-bit gray levels, registered lookup.
// Assumes writes and lookups come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module lpb_palette
  import lpb_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        wr_lo_i,
  input  wire logic        wr_hi_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  index_i,
  output logic      [63:0] table_o,
  output logic      [3:0]  level_o
);
  typedef struct packed {
    logic [63:0] pal;
    logic [3:0]  lvl;
  } lpb_pal_state_t;
  lpb_pal_state_t s_r;
  lpb_pal_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (wr_lo_i) begin
      s_nxt.pal[31:0] = wdata_i;
    end
    if (wr_hi_i) begin
      s_nxt.pal[63:32] = wdata_i;
    end
    s_nxt.lvl = s_r.pal[{index_i, 2'b00} +: 4];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '{pal: {LPB_PAL_RESET, LPB_PAL_RESET}, lvl: 4'h0};
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign table_o = s_r.pal;
  assign level_o = s_r.lvl;
endmodule
`default_nettype wire

//--- lpb_timing_properties.sv
// Checker bound to lpb_timing ports.
// Assumes ce_i stays high; shadows control writes.
`timescale 1ns/100ps
`default_nettype none
module lpb_chk
  import lpb_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [3:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        pixel_req_o,
  input wire logic        pixel_shift_clock_o,
  input wire logic        line_clock_pulse_o,
  input wire logic [1:0]  bits_per_pixel_o
);
  logic [31:0] c_r;
  logic [7:0]  hc_r, lc_r, hp, lp;
  logic [10:0] pc_r, px;
  logic [1:0]  ls_r, b;
  logic        pk, ln, wc;
  assign pk = pixel_shift_clock_o;
  assign ln = line_clock_pulse_o;
  assign b = bits_per_pixel_o;
  assign wc = wr_i && addr_i == LPB_ADDR_CTRL;
  assign hp = ({2'h0, c_r[24:19]} + 8'h01) >> 1;
  assign lp = {2'h0, c_r[24:19]} + 8'h01 - hp;
  assign px = ({5'h00, c_r[18:13]} + 11'h001) << 4;
  // High, low and line-length checks wait three lines after a write, skipping mixed periods
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      c_r <= 32'h0;
      ls_r <= 2'h0;
      hc_r <= 8'h00;
      lc_r <= 8'h00;
      pc_r <= 11'h000;
    end else begin
      if (wc) c_r <= wdata_i;
      ls_r <= wc ? 2'h0 : ls_r + 2'(ls_r != 2'h3 && ln);
      hc_r <= pk ? hc_r + 8'h01 : 8'h00;
      lc_r <= pk ? 8'h00 : lc_r + 8'h01;
      pc_r <= ln ? 11'(pixel_req_o) : pc_r + 11'(pixel_req_o);
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_hi; $fell(pk) && ls_r == 2'h3 |-> hc_r == hp; endproperty
  a_hi: assert property (p_hi) else $error("pclk high time");
  property p_req; pixel_req_o |-> pk ##1 !pk; endproperty
  a_req: assert property (p_req) else $error("pixel request");
  property p_off; (c_r[24:19] == 6'h00) [*3] |-> !pk && !pixel_req_o; endproperty
  a_off: assert property (p_off) else $error("pclk not stopped");
  property p_lo; $rose(pk) && ls_r == 2'h3 |-> lc_r == lp || lc_r == {lp[6:0], 1'b0}; endproperty
  a_lo: assert property (p_lo) else $error("pclk low time");
  property p_len; ln && ls_r == 2'h3 |-> pc_r == px; endproperty
  a_len: assert property (p_len) else $error("line length");
  property p_d1; !c_r[30] |-> b == 2'h0; endproperty
  a_d1: assert property (p_d1) else $error("depth 1");
  property p_d4; c_r[30] |-> b == {c_r[31], 1'b1}; endproperty
  a_d4: assert property (p_d4) else $error("depth 2 or 4");
  property p_d10; c_r[31:30] == 2'h2 |-> b == 2'h0; endproperty
  a_d10: assert property (p_d10) else $error("depth code 10");
  c_len: cover property (ln && ls_r == 2'h3);
  c_hi: cover property ($fell(pk) && ls_r == 2'h3);
  c_d10: cover property (c_r[31:30] == 2'h2);
endmodule
bind lpb_timing lpb_chk i_lpb_chk (.*);
`default_nettype wire

//--- lpb_panel.sv
// Passive panel model: line period and bias toggle spacing.
// Assumes it samples the LCD outputs on the system clock.
`timescale 1ns/100ps
`default_nettype none
module lpb_panel (
  input  wire logic clk_i,
  input  wire logic line_i,
  input  wire logic bias_i,
  input  wire logic frame_i,
  output var  int   line_per_o = 0,
  output var  int   bias_lines_o = 0,
  output var  int   frame_lines_o = 0
);
  int   cyc = 0;
  int   nl = 0;
  int   fl = 0;
  logic bias_q = 1'b0;
  always @(posedge clk_i) begin
    bias_q <= bias_i;
    cyc <= line_i ? 1 : cyc + 1;
    if (line_i) line_per_o <= cyc;
    // Pulse on a toggle edge counts toward the next span
    if (bias_i != bias_q) begin
      bias_lines_o <= nl;
      nl <= int'(line_i);
    end else begin
      nl <= nl + int'(line_i);
    end
    // Frame pulse rides on the closing line pulse of the frame
    if (frame_i) begin
      frame_lines_o <= fl;
      fl <= 1;
    end else begin
      fl <= fl + int'(line_i);
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
// Bench for lpb_timing: register tasks and panel timing checks.
// Assumes package, design, panel model and checker are compiled.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import lpb_pkg::*;
  logic        clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  // Fixed pixel value: each depth picks a different palette slot
  logic [3:0]  addr_i = 4'h0, pixel_data_i = 4'hE, gray_level_o;
  logic [31:0] wdata_i = 32'h0, rdata_o, c;
  logic        pixel_req_o, pixel_shift_clock_o, line_clock_pulse_o, frame_start_o, ac_bias_o;
  logic [1:0]  bits_per_pixel_o;
  int          errors = 0, n_tests = 0, lper, blin, flin;
  // Short frame so a whole one fits in the run
  localparam int LINES = 10;
  logic [3:0]  lvl [4] = '{4'h8, 4'h6, 4'h8, 4'hA};
  always #12.5 clk_i = ~clk_i;
  lpb_timing #(.LINES(LINES)) i_lpb_timing (.*);
  lpb_panel i_lpb_panel (.clk_i(clk_i), .line_i(line_clock_pulse_o), .bias_i(ac_bias_o),
    .frame_i(frame_start_o), .line_per_o(lper), .bias_lines_o(blin), .frame_lines_o(flin));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 cmp(rdata_o, e);
  endtask
  task automatic test_done;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(LPB_ADDR_CTRL, 32'h0);
    wr(4'h7, 32'hFFFF_FFFF);
    rd(4'h7, 32'h0);
    wr(LPB_ADDR_PAL_LO, 32'h1234_5678);
    wr(LPB_ADDR_PAL_HI, 32'h9ABC_DEF0);
    rd(LPB_ADDR_PAL_HI, 32'h9ABC_DEF0);
    rd(LPB_ADDR_PAL_LO, 32'h1234_5678);
    // AC value 13 keeps bias spans off the line count
    for (int i = 0; i < 4; i++) begin
      c = {i[1:0], 5'h0D, 6'h01, 6'h01, 13'h0000};
      wr(LPB_ADDR_CTRL, c);
      rd(LPB_ADDR_CTRL, c);
      cmp({30'h0, bits_per_pixel_o}, {30'h0, i[1] & i[0], i[0]});
      repeat (12) @(posedge clk_i);
      cmp({28'h0, gray_level_o}, {28'h0, lvl[i]});
    end
    for (int p = 1; p < 4; p += 2) begin
      wr(LPB_ADDR_CTRL, {2'h3, 5'h0D, p[5:0], 6'h01, 13'h0000});
      repeat (9000) @(posedge clk_i);
      cmp(lper, 32 * (p + 1) + (p + 1) - (p + 1) / 2);
      cmp(blin, 14);
      cmp(flin, LINES);
      cmp({28'h0, gray_level_o}, 32'hA);
    end
    wr(LPB_ADDR_CTRL, 32'h0);
    repeat (200) @(posedge clk_i);
    cmp({31'h0, pixel_shift_clock_o}, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
